/* File: core/adcrd_pkg.sv */
package adcrd_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int RES_W = 13;                  // 12 bits plus sign
  localparam int SIGN_BIT = 12;               // msb carries the sign
  localparam int NCH = 2;                     // two channels per device
  typedef logic [RES_W-1:0] adcrd_word_t;     // one conversion code
  typedef logic [NCH-1:0][RES_W-1:0] adcrd_pair_t; // both channels
  localparam adcrd_word_t SIGN_MASK = 13'h1000; // flips offset binary to two's complement
  localparam logic [3:0] FIRST_IDX = 4'hC;    // first decision bit
  localparam logic [3:0] LAST_IDX = 4'h0;     // last decision bit
  localparam logic [3:0] BITS_PER_WORD = 4'hD; // shift pulses per frame

  // ----------------------------------------------------------------
  // code ranges per input drive
  // ----------------------------------------------------------------
  localparam adcrd_word_t FULL_MIN = 13'h1000;  // fully differential
  localparam adcrd_word_t FULL_MAX = 13'h0FFF;
  localparam adcrd_word_t BIP_MIN = 13'h1800;   // pseudo-differential bipolar
  localparam adcrd_word_t BIP_MAX = 13'h07FF;
  localparam adcrd_word_t UNI_MIN = 13'h0000;   // pseudo-differential unipolar
  localparam adcrd_word_t UNI_MAX = 13'h0FFF;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MCLK_NS = 8;                 // 125 MHz system clock
  localparam int T_CNVH_NS = 35;              // least convert high time
  localparam int T_QUIET_NS = 10;             // shift quiet after convert fall
  localparam int T_SCK_CNVH_NS = 20;          // last shift to convert rise
  localparam int CNVH_CYC = (T_CNVH_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int QUIET_CYC = (T_QUIET_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int SCK_CNVH_CYC = (T_SCK_CNVH_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int SCK_HALF_CYC = 8;            // host shift clock half period

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SE = 2'h0,                           // mode pin grounded
    MODE_DIFF = 2'h1,                         // mode pin at io supply
    MODE_LPDIFF = 2'h2                        // mode pin floating
  } adcrd_mode_e;

  typedef enum logic [2:0] {
    DS_ACQ = 3'h1,
    DS_CONV = 3'h2,
    DS_DONE = 3'h4
  } adcrd_dstate_e;

  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_LOW = 5'h02,
    HS_SHIFT = 5'h04,
    HS_DRAIN = 5'h08,
    HS_PUSH = 5'h10
  } adcrd_hstate_e;

endpackage

/* File: core/adcrd_link_if.sv */
interface adcrd_link_if;
  logic convert_strobe;     // host to device, single ended always
  logic shift_clk_p;        // host shift clock, positive leg
  logic shift_clk_n;        // host shift clock, negative leg
  logic ch1_serial_out_p;   // channel 1 data legs
  logic ch1_serial_out_n;
  logic ch2_serial_out_p;   // channel 2 data legs
  logic ch2_serial_out_n;
  logic echo_clock_p;       // echo clock positive leg
  logic echo_n_out;         // device drive of echo negative leg
  logic echo_n_oe;          // device enables echo negative leg
  logic echo_n_tie;         // host side strap level on echo negative leg
  logic echo_clock_n;       // resolved echo negative leg

  // the strap only shows while the device leaves the leg undriven
  assign echo_clock_n = echo_n_oe ? echo_n_out : echo_n_tie;

  modport dev (
    input convert_strobe, shift_clk_p, shift_clk_n, echo_clock_n,
    output ch1_serial_out_p, ch1_serial_out_n, ch2_serial_out_p, ch2_serial_out_n,
    output echo_clock_p, echo_n_out, echo_n_oe
  );

  modport host (
    output convert_strobe, shift_clk_p, shift_clk_n, echo_n_tie,
    input ch1_serial_out_p, ch1_serial_out_n, ch2_serial_out_p, ch2_serial_out_n,
    input echo_clock_p, echo_clock_n
  );
endinterface

/* File: core/adcrd_dev_end.sv */
// Behaviour
// - convert high: track both channel inputs
// - convert falling starts conversion and output
// - shift falling edge advances data, msb first
// - single ended: drive positive legs only
// - differential: drive data on both legs
// - echo clock skew matched to data
// - single ended: echo negative tied high disables echo
// - mode pin picks single, differential, low power
// - host drives shift clock per mode
// - convert input ignores the signalling mode
// - result is two's complement, msb is sign
// - first approximation decision at convert fall, then one per shift fall
// - final 13-bit code formed per channel
// - fully differential spans whole code range
// - bipolar span flags over and under range
// - unipolar span runs zero to top code
module adcrd_dev_end (
  input wire logic mclk,                          // system clock
  input wire logic nrst,                          // async reset, active low
  adcrd_link_if.dev link,                         // serial link pins
  input wire adcrd_pkg::adcrd_pair_t ch_analog,   // sampled input per channel
  input wire adcrd_pkg::adcrd_mode_e io_mode,     // mode strap level
  output logic acquiring,                         // high in acquisition phase
  output logic result_valid,                      // pulse when codes are final
  output adcrd_pkg::adcrd_pair_t ch_result,       // final codes
  output logic [1:0] over_range,                  // code above bipolar span
  output logic [1:0] under_range,                 // code below bipolar span
  output logic low_power                          // low power differential mode
);
  import adcrd_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cnv_m_q, cnv_s_q, cnv_p_q;       // convert strobe stages and history
  logic sck_m_q, sck_s_q, sck_p_q;       // shift clock stages and history
  logic ecn_m_q, ecn_s_q;                // echo negative leg strap
  adcrd_mode_e mode_m_q, mode_s_q;       // mode strap stages

  // first stages feed only the second stages
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnv_m_q <= 1'b1;
      cnv_s_q <= 1'b1;
      cnv_p_q <= 1'b1;
      sck_m_q <= 1'b0;
      sck_s_q <= 1'b0;
      sck_p_q <= 1'b0;
      ecn_m_q <= 1'b0;
      ecn_s_q <= 1'b0;
      mode_m_q <= MODE_SE;
      mode_s_q <= MODE_SE;
    end else begin
      cnv_m_q <= link.convert_strobe;    // same input path in every mode
      cnv_s_q <= cnv_m_q;
      cnv_p_q <= cnv_s_q;
      // the differential receiver resolves to the positive leg's sense
      sck_m_q <= link.shift_clk_p;
      sck_s_q <= sck_m_q;
      sck_p_q <= sck_s_q;
      ecn_m_q <= link.echo_clock_n;
      ecn_s_q <= ecn_m_q;
      mode_m_q <= io_mode;
      mode_s_q <= mode_m_q;
    end
  end

  // ----------------------------------------------------------------
  // control sequence
  // ----------------------------------------------------------------
  adcrd_dstate_e st_q, st_d;             // phase
  logic [3:0] idx_q, idx_d;              // bit under decision
  logic valid_q, valid_d;                // end of conversion pulse
  logic diff_q, diff_d;                  // differential signalling
  logic lp_q, lp_d;                      // low power variant
  logic echo_p_q, echo_p_d;              // echo positive leg
  logic echo_n_q, echo_n_d;              // echo negative leg drive
  logic echo_oe_q, echo_oe_d;            // echo negative leg enable
  logic cnv_fall, sck_fall, step;        // events in this cycle
  logic echo_en;                         // echo allowed to toggle

  assign cnv_fall = cnv_p_q & ~cnv_s_q;
  assign sck_fall = sck_p_q & ~sck_s_q;
  assign step = ((st_q == DS_ACQ) & cnv_fall) | ((st_q == DS_CONV) & sck_fall);
  // negative leg is an input only in single ended mode
  assign echo_en = diff_q | ~ecn_s_q;

  // next phase, decision index and pin levels
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    valid_d = 1'b0;
    diff_d = (mode_s_q != MODE_SE);
    lp_d = (mode_s_q == MODE_LPDIFF);
    echo_p_d = echo_en & sck_s_q;
    echo_n_d = diff_q & ~sck_s_q;
    echo_oe_d = diff_q;
    unique case (st_q)
      DS_ACQ: begin
        idx_d = FIRST_IDX;
        if (cnv_fall) begin
          st_d = DS_CONV;
          idx_d = FIRST_IDX - 4'h1;
        end
      end
      DS_CONV: begin
        if (cnv_s_q) begin
          // an early convert rise abandons the frame
          st_d = DS_ACQ;
        end else if (sck_fall) begin
          if (idx_q == LAST_IDX) begin
            st_d = DS_DONE;
            valid_d = 1'b1;
          end else begin
            idx_d = idx_q - 4'h1;
          end
        end
      end
      DS_DONE: begin
        // extra shift pulses change nothing until the next sample
        if (cnv_s_q) begin
          st_d = DS_ACQ;
        end
      end
      default: begin
        st_d = DS_ACQ;
      end
    endcase
  end

  // control registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= DS_ACQ;
      idx_q <= FIRST_IDX;
      valid_q <= 1'b0;
      diff_q <= 1'b0;
      lp_q <= 1'b0;
      echo_p_q <= 1'b0;
      echo_n_q <= 1'b0;
      echo_oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      valid_q <= valid_d;
      diff_q <= diff_d;
      lp_q <= lp_d;
      echo_p_q <= echo_p_d;
      echo_n_q <= echo_n_d;
      echo_oe_q <= echo_oe_d;
    end
  end

  // ----------------------------------------------------------------
  // per channel approximation
  // ----------------------------------------------------------------
  logic [1:0] ser_p_q, ser_n_q;          // data leg levels per channel
  adcrd_pair_t code_q;                   // final codes
  logic [1:0] ovr_q, und_q;              // range flags

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    adcrd_word_t samp_q, samp_d;         // held input
    adcrd_word_t res_q, res_d;           // offset binary approximation
    adcrd_word_t code_d;
    logic ser_p_d, ser_n_d, ovr_d, und_d;

    // one decision per step; the sign decision is inverted on the wire
    always_comb begin
      adcrd_word_t trial;
      logic keep;
      trial = res_q | (adcrd_word_t'(1) << idx_q);
      keep = (trial <= (samp_q ^ SIGN_MASK));
      samp_d = samp_q;
      res_d = res_q;
      code_d = code_q[g];
      ser_p_d = ser_p_q[g];
      ovr_d = ovr_q[g];
      und_d = und_q[g];
      if (st_q == DS_ACQ) begin
        res_d = '0;
        ser_p_d = 1'b0;                  // legs idle while sampling
        if (cnv_s_q) begin
          samp_d = ch_analog[g];
        end
      end
      if (step) begin
        res_d = keep ? trial : res_q;
        ser_p_d = keep ^ (idx_q == FIRST_IDX);
        if (idx_q == LAST_IDX) begin
          code_d = res_d ^ SIGN_MASK;
          // signed compare against the bipolar span
          ovr_d = $signed(code_d) > $signed(BIP_MAX);
          und_d = $signed(code_d) < $signed(BIP_MIN);
        end
      end
      ser_n_d = diff_q & ~ser_p_d;
    end

    // channel registers
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        samp_q <= '0;
        res_q <= '0;
        code_q[g] <= '0;
        ser_p_q[g] <= 1'b0;
        ser_n_q[g] <= 1'b0;
        ovr_q[g] <= 1'b0;
        und_q[g] <= 1'b0;
      end else begin
        samp_q <= samp_d;
        res_q <= res_d;
        code_q[g] <= code_d;
        ser_p_q[g] <= ser_p_d;
        ser_n_q[g] <= ser_n_d;
        ovr_q[g] <= ovr_d;
        und_q[g] <= und_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign link.ch1_serial_out_p = ser_p_q[0];
  assign link.ch1_serial_out_n = ser_n_q[0];
  assign link.ch2_serial_out_p = ser_p_q[1];
  assign link.ch2_serial_out_n = ser_n_q[1];
  // echo and data leave on the same edge, so they stay aligned
  assign link.echo_clock_p = echo_p_q;
  assign link.echo_n_out = echo_n_q;
  assign link.echo_n_oe = echo_oe_q;
  assign acquiring = st_q[0];
  assign result_valid = valid_q;
  assign ch_result = code_q;
  assign over_range = ovr_q;
  assign under_range = und_q;
  assign low_power = lp_q;
endmodule

/* File: core/adcrd_host_end.sv */
// ------------------------------------------------------------------
// result fifo
// ------------------------------------------------------------------
module adcrd_fifo #(
  parameter int W = 26,                  // word width
  parameter int DEPTH = 16               // entries, power of two
) (
  input wire logic mclk,                 // system clock
  input wire logic nrst,                 // async reset, active low
  input wire logic in_valid,             // write request
  output logic in_ready,                 // room for a word
  input wire logic [W-1:0] in_data,      // write word
  output logic out_valid,                // word available
  input wire logic out_ready,            // reader takes word
  output logic [W-1:0] out_data          // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];             // storage
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;   // pointers with wrap bit
  logic full, empty;
  logic avail_q, avail_d;                // registered word available

  assign full = (wp_q[AW] != rp_q[AW]) & (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty = (wp_q == rp_q);
  assign in_ready = ~full;
  assign out_valid = avail_q;
  assign out_data = mem[rp_q[AW-1:0]];

  // pointer moves
  always_comb begin
    wp_d = wp_q + (AW+1)'(in_valid & ~full);
    rp_d = rp_q + (AW+1)'(out_ready & ~empty);
    avail_d = (wp_d != rp_d);
  end

  // pointers and storage; storage needs no reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      avail_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      avail_q <= avail_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (in_valid & ~full) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------------
// host end
// ------------------------------------------------------------------
module adcrd_host_end #(
  parameter int HALF = adcrd_pkg::SCK_HALF_CYC, // shift clock half period
  parameter int DEPTH = 16                       // fifo entries
) (
  input wire logic mclk,                          // system clock
  input wire logic nrst,                          // async reset, active low
  adcrd_link_if.host link,                        // serial link pins
  input wire logic acq_req,                       // level: run conversions
  input wire adcrd_pkg::adcrd_mode_e io_mode,     // mode the device is strapped to
  input wire logic echo_tie_high,                 // strap echo negative leg high
  output logic word_valid,                        // pair available
  input wire logic word_ready,                    // reader takes pair
  output adcrd_pkg::adcrd_pair_t word_data,       // ch2 high, ch1 low
  output logic busy                               // frame in progress
);
  import adcrd_pkg::*;

  // ----------------------------------------------------------------
  // return path synchronisers
  // ----------------------------------------------------------------
  logic [2:0] rx_m_q, rx_s_q;            // echo, ch2, ch1 stages
  logic echo_p_q;                        // echo history
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_m_q <= '0;
      rx_s_q <= '0;
      echo_p_q <= 1'b0;
    end else begin
      rx_m_q <= {link.echo_clock_p, link.ch2_serial_out_p, link.ch1_serial_out_p};
      rx_s_q <= rx_m_q;
      echo_p_q <= rx_s_q[2];
    end
  end

  // ----------------------------------------------------------------
  // frame sequence
  // ----------------------------------------------------------------
  adcrd_hstate_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;              // phase timer
  logic [3:0] falls_q, falls_d;          // shift falls issued
  logic [3:0] got_q, got_d;              // bits captured
  logic sck_q, sck_d, cnv_q, cnv_d, busy_q, busy_d;
  logic tie_q, tie_d, diff_q, diff_d;
  adcrd_pair_t sh_q, sh_d;               // capture shifters
  logic cap, push, fifo_rdy;

  // wait for the echo when it runs, else use own rising edge
  assign cap = tie_q ? ((st_q == HS_SHIFT) & ~sck_q & (cnt_q == 8'(HALF - 1)))
                     : (rx_s_q[2] & ~echo_p_q);
  assign push = (st_q == HS_PUSH);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 8'h1;
    falls_d = falls_q;
    got_d = got_q;
    sck_d = sck_q;
    cnv_d = cnv_q;
    busy_d = busy_q;
    sh_d = sh_q;
    tie_d = (io_mode == MODE_SE) & echo_tie_high;
    diff_d = (io_mode != MODE_SE);
    if (cap & (got_q != BITS_PER_WORD)) begin
      sh_d[0] = {sh_q[0][RES_W-2:0], rx_s_q[0]};
      sh_d[1] = {sh_q[1][RES_W-2:0], rx_s_q[1]};
      got_d = got_q + 4'h1;
    end
    unique case (st_q)
      HS_IDLE: begin
        cnv_d = 1'b1;
        busy_d = 1'b0;
        // back-pressure: no frame starts without fifo room
        if (acq_req & fifo_rdy & (cnt_q >= 8'(CNVH_CYC))) begin
          st_d = HS_LOW;
          cnv_d = 1'b0;
          busy_d = 1'b1;
          cnt_d = '0;
          falls_d = '0;
          got_d = '0;
        end
      end
      HS_LOW: begin
        if (cnt_q >= 8'(QUIET_CYC)) begin
          st_d = HS_SHIFT;
          cnt_d = '0;
        end
      end
      HS_SHIFT: begin
        if (cnt_q == 8'(HALF - 1)) begin
          cnt_d = '0;
          sck_d = ~sck_q;
          if (sck_q) begin
            falls_d = falls_q + 4'h1;
            if (falls_q == BITS_PER_WORD - 4'h1) begin
              st_d = HS_DRAIN;
            end
          end
        end
      end
      HS_DRAIN: begin
        // hold convert low long enough after the last shift
        if ((got_q == BITS_PER_WORD) & (cnt_q >= 8'(SCK_CNVH_CYC))) begin
          st_d = HS_PUSH;
        end
      end
      HS_PUSH: begin
        st_d = HS_IDLE;
        cnv_d = 1'b1;
        cnt_d = '0;
      end
      default: begin
        st_d = HS_IDLE;
      end
    endcase
  end

  // frame registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= HS_IDLE;
      cnt_q <= '0;
      falls_q <= '0;
      got_q <= '0;
      sck_q <= 1'b0;
      cnv_q <= 1'b1;
      busy_q <= 1'b0;
      tie_q <= 1'b0;
      diff_q <= 1'b0;
      sh_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      falls_q <= falls_d;
      got_q <= got_d;
      sck_q <= sck_d;
      cnv_q <= cnv_d;
      busy_q <= busy_d;
      tie_q <= tie_d;
      diff_q <= diff_d;
      sh_q <= sh_d;
    end
  end

  assign link.convert_strobe = cnv_q;
  assign link.shift_clk_p = sck_q;
  assign link.shift_clk_n = diff_q & ~sck_q;
  assign link.echo_n_tie = tie_q;
  assign busy = busy_q;

  adcrd_fifo #(.W(2 * RES_W), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(fifo_rdy),
    .in_data(sh_q),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );
endmodule

/* File: verif/adcrd_link_properties.sv */
// ----------------------------------------------------------------
// link checker, watches both ends across the interface
// ----------------------------------------------------------------
module adcrd_link_properties (
  input wire logic mclk,             // system clock
  input wire logic nrst,             // async reset, active low
  input wire logic convert_strobe,   // host convert level
  input wire logic shift_clk_p,      // shift clock positive leg
  input wire logic shift_clk_n,      // shift clock negative leg
  input wire logic ch1_serial_out_p, // channel 1 positive leg
  input wire logic ch1_serial_out_n, // channel 1 negative leg
  input wire logic ch2_serial_out_p, // channel 2 positive leg
  input wire logic ch2_serial_out_n, // channel 2 negative leg
  input wire logic echo_clock_p,     // echo clock positive leg
  input wire logic echo_n_out,       // device drive of echo negative leg
  input wire logic echo_n_oe,        // device enable of echo negative leg
  input wire logic echo_n_tie        // host strap on echo negative leg
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // the strap only wins while the device leaves the leg undriven
  wire echo_on = echo_n_oe || !echo_n_tie;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // five cycles of slack cover the synchroniser lag after a rise
  acq_legs_low_a: assert property (convert_strobe [*5]
    |-> !ch1_serial_out_p && !ch2_serial_out_p)
    else $error("data legs driven while acquiring");
  cnv_high_min_a: assert property ($rose(convert_strobe) |-> convert_strobe [*5])
    else $error("convert high time too short");
  shift_quiet_a: assert property ($fell(convert_strobe) |-> !shift_clk_p [*2])
    else $error("shift clock rose inside quiet time");
  data_legs_a: assert property (!echo_n_oe |-> !ch1_serial_out_n && !ch2_serial_out_n)
    else $error("negative data legs driven in single ended mode");
  diff_pair_a: assert property ((!convert_strobe && shift_clk_n) [*6]
    |-> ch1_serial_out_n != ch1_serial_out_p)
    else $error("data legs not a differential pair");
  sck_legs_a: assert property (!(shift_clk_p && shift_clk_n))
    else $error("shift clock legs both high");
  echo_rise_a: assert property ($rose(shift_clk_p) && echo_on |-> ##[2:5] echo_clock_p)
    else $error("echo clock did not follow shift rise");
  echo_fall_a: assert property ($fell(shift_clk_p) && echo_on |-> ##[2:5] !echo_clock_p)
    else $error("echo clock did not follow shift fall");
  echo_pair_a: assert property (echo_n_oe |-> echo_n_out != echo_clock_p)
    else $error("echo legs not a differential pair");
  echo_off_a: assert property ((!echo_n_oe && echo_n_tie) [*4] |-> !echo_clock_p)
    else $error("echo clock running while strapped off");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  frame_c: cover property ($fell(convert_strobe));
  echo_off_c: cover property (!echo_on && $fell(shift_clk_p));
  diff_c: cover property (echo_n_oe && $fell(shift_clk_p));
endmodule

/* File: verif/adcrd_tb_top.sv */
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module adcrd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcrd_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic mclk, nrst, acq_req, echo_tie_high, word_ready;
  logic acquiring, result_valid, low_power, word_valid, busy;
  logic [1:0] over_range, under_range;
  adcrd_pair_t ch_analog, ch_result, word_data;
  adcrd_mode_e io_mode;
  int err_total, total_checks, rv_cnt;
  // boundary codes of every input span plus one past the bipolar span each way
  adcrd_word_t vals [7] = '{FULL_MIN, FULL_MAX, 13'h17FF, 13'h0800, UNI_MIN, BIP_MIN, BIP_MAX};

  adcrd_link_if u_link ();
  adcrd_dev_end u_adcrd_dev_end (.mclk(mclk), .nrst(nrst), .link(u_link), .ch_analog(ch_analog),
    .io_mode(io_mode), .acquiring(acquiring), .result_valid(result_valid),
    .ch_result(ch_result), .over_range(over_range), .under_range(under_range),
    .low_power(low_power));
  adcrd_host_end u_adcrd_host_end (.mclk(mclk), .nrst(nrst), .link(u_link), .acq_req(acq_req),
    .io_mode(io_mode), .echo_tie_high(echo_tie_high), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .busy(busy));
  adcrd_link_properties u_adcrd_link_properties (.mclk(mclk), .nrst(nrst),
    .convert_strobe(u_link.convert_strobe), .shift_clk_p(u_link.shift_clk_p),
    .shift_clk_n(u_link.shift_clk_n), .ch1_serial_out_p(u_link.ch1_serial_out_p),
    .ch1_serial_out_n(u_link.ch1_serial_out_n), .ch2_serial_out_p(u_link.ch2_serial_out_p),
    .ch2_serial_out_n(u_link.ch2_serial_out_n),
    .echo_clock_p(u_link.echo_clock_p), .echo_n_out(u_link.echo_n_out),
    .echo_n_oe(u_link.echo_n_oe), .echo_n_tie(u_link.echo_n_tie));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // take one pair from the fifo, ready held for exactly one sampling edge
  task automatic pop(input adcrd_pair_t exp);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (word_valid !== 1'b1 && n < 100);
    `CHK("word", exp, word_data)
    @(posedge mclk);
    word_ready <= 1'b1;
    @(posedge mclk);
    word_ready <= 1'b0;
  endtask

  // one conversion; the wire is sampled at each shift rise like a host would
  task automatic frame(input adcrd_word_t a1, input adcrd_word_t a2, input bit pop_it);
    adcrd_word_t sh, sh2;
    logic [1:0] ov, un;
    int n, rises, bad;
    logic sp, rv_seen, acq_rv;
    sh = '0;
    sh2 = '0;
    n = 0;
    rises = 0;
    bad = 0;
    sp = 1'b0;
    rv_seen = 1'b0;
    acq_rv = 1'b1;
    ov = {$signed(a2) > $signed(BIP_MAX), $signed(a1) > $signed(BIP_MAX)};
    un = {$signed(a2) < $signed(BIP_MIN), $signed(a1) < $signed(BIP_MIN)};
    @(negedge mclk);
    `CHK("acquiring", 1'b1, acquiring)
    @(posedge mclk);
    ch_analog <= {a2, a1};
    acq_req <= 1'b1;
    // the request is a level, held until the host starts the frame
    do begin
      @(negedge mclk);
      n++;
    end while (busy !== 1'b1 && n < 200);
    @(posedge mclk);
    acq_req <= 1'b0;
    // follow the whole frame: the last rise comes after the device result
    while (busy === 1'b1 && n < 1200) begin
      @(negedge mclk);
      n++;
      if (result_valid === 1'b1) begin
        rv_seen = 1'b1;
        acq_rv = acquiring;
      end
      if (u_link.shift_clk_p === 1'b1 && sp === 1'b0) begin
        sh = {sh[11:0], u_link.ch1_serial_out_p};
        sh2 = {sh2[11:0], u_link.ch2_serial_out_p};
        rises++;
      end
      sp = u_link.shift_clk_p;
      if (io_mode == MODE_SE && (u_link.ch1_serial_out_n | u_link.ch2_serial_out_n) !== 1'b0)
        bad++;
    end
    if (rv_seen === 1'b1) begin
      rv_cnt++;
      `CHK("result", {a2, a1}, ch_result)
      `CHK("over_range", ov, over_range)
      `CHK("under_range", un, under_range)
      `CHK("converting", 1'b0, acq_rv)
      `CHK("wire_bits", a1, sh)
      `CHK("wire_bits2", a2, sh2)
      `CHK("shift_pulses", 13, rises)
      `CHK("se_neg_legs", 0, bad)
    end
    if (pop_it)
      pop({a2, a1});
    repeat (8) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // about 10k cycles expected, so this leaves ample margin
  initial begin
    #300us;
    err_total++;
    wrap_up();
  end

  initial begin
    nrst = 1'b0;
    acq_req = 1'b0;
    word_ready = 1'b0;
    echo_tie_high = 1'b0;
    io_mode = MODE_SE;
    ch_analog = '0;
    err_total = 0;
    total_checks = 0;
    rv_cnt = 0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    // single ended, single ended with echo off, differential, low power differential
    for (int c = 0; c < 4; c++) begin
      @(posedge mclk);
      io_mode <= (c < 2) ? MODE_SE : (c == 2) ? MODE_DIFF : MODE_LPDIFF;
      echo_tie_high <= (c == 1);
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      `CHK("low_power", c == 3, low_power)
      rv_cnt = 0;
      for (int i = 0; i < 7; i++)
        frame(vals[i], vals[6 - i], 1'b1);
      `CHK("frames", 7, rv_cnt)
    end
    // reader stalls: sixteen frames fill the fifo, the seventeenth is refused
    rv_cnt = 0;
    for (int k = 0; k < 17; k++)
      frame(13'(k * 37), ~13'(k * 37), 1'b0);
    `CHK("fifo_frames", 16, rv_cnt)
    for (int k = 0; k < 16; k++)
      pop({~13'(k * 37), 13'(k * 37)});
    @(negedge mclk);
    `CHK("fifo_empty", 1'b0, word_valid)
    wrap_up();
  end
endmodule
